// *** verilog/crie_regs.vh ***
`ifndef CRIE_REGS_VH
`define CRIE_REGS_VH

// ****************************************
// Register addresses on the plain port
// ****************************************
`define CRIE_ADDR_W 8
`define CRIE_ADDR_FLAG 8'h04
`define CRIE_ADDR_IEN 8'h05

// ****************************************
// Field positions, shared by flag and enable registers
// ****************************************
`define CRIE_BIT_WAKE 7
`define CRIE_BIT_CSC 6
`define CRIE_RX_HI 5
`define CRIE_RX_LO 4
`define CRIE_TX_HI 3
`define CRIE_TX_LO 2
`define CRIE_BIT_OVR 1
`define CRIE_BIT_RXF 0

// ****************************************
// Reset values
// ****************************************
`define CRIE_IEN_RESET 8'h00
`define CRIE_FLAG_RESET 8'h00
`define CRIE_STATE_RESET 2'h0

// ****************************************
// Error state thresholds and encodings
// ****************************************
`define CRIE_WARN_LIMIT 96
`define CRIE_PASSIVE_LIMIT 127
`define CRIE_BUS_OFF_LIMIT 255
`define CRIE_ST_OK 2'h0
`define CRIE_ST_WARN 2'h1
`define CRIE_ST_PASSIVE 2'h2
`define CRIE_ST_BUS_OFF 2'h3
`define CRIE_SENS_NONE 2'h0
`define CRIE_SENS_BUS_OFF 2'h1
`define CRIE_SENS_PASSIVE 2'h2
`define CRIE_SENS_ALL 2'h3

`endif

// *** verilog/crie_state_enc.v ***
`timescale 1ns/1ps
`include "crie_regs.vh"

// ****************************************
// Error state encoder and sensitivity filter
// ****************************************
module crie_state_enc #(
    parameter CNT_W = 9
) (
    input wire [CNT_W-1:0] err_count_i,
    input wire bus_off_i,
    input wire [1:0] shown_state_i,
    input wire [1:0] sensitivity_i,
    output reg [1:0] actual_state_o,
    output reg change_hit_o
);

    localparam [CNT_W-1:0] WARN_LIM = `CRIE_WARN_LIMIT;
    localparam [CNT_W-1:0] PASS_LIM = `CRIE_PASSIVE_LIMIT;

    reg changed;

    // Bus-off dominates; otherwise the counter decides the band
    always @* begin
        if (bus_off_i) begin
            actual_state_o = `CRIE_ST_BUS_OFF;
        end else if (err_count_i > PASS_LIM) begin
            actual_state_o = `CRIE_ST_PASSIVE;
        end else if (err_count_i > WARN_LIM) begin
            actual_state_o = `CRIE_ST_WARN;
        end else begin
            actual_state_o = `CRIE_ST_OK;
        end
    end

    // Compare against the last shown state, not the last actual state
    always @* begin
        changed = (actual_state_o != shown_state_i);
        case (sensitivity_i)
            `CRIE_SENS_BUS_OFF: change_hit_o = changed &&
                ((actual_state_o == `CRIE_ST_BUS_OFF) || (shown_state_i == `CRIE_ST_BUS_OFF));
            `CRIE_SENS_PASSIVE: change_hit_o = changed && (actual_state_o[1] || shown_state_i[1]);
            `CRIE_SENS_ALL: change_hit_o = changed;
            default: change_hit_o = 1'b0;
        endcase
    end

endmodule

// *** verilog/crie_top.v ***
`timescale 1ns/1ps
`include "crie_regs.vh"

module crie_top #(
    parameter REC_W = 8,
    parameter TEC_W = 9
) (
    input wire clk_sys_i,
    input wire rst_n_i,
    input wire [7:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output reg [7:0] reg_rdata_o,
    input wire init_request_i,
    input wire init_acknowledge_i,
    input wire wake_up_enable_i,
    input wire wake_event_i,
    input wire overrun_event_i,
    input wire rx_full_event_i,
    input wire [REC_W-1:0] rx_err_count_i,
    input wire [TEC_W-1:0] tx_err_count_i,
    output reg wake_irq_o,
    output reg error_irq_o,
    output reg rx_irq_o,
    output reg irq_o
);

    // ****************************************
    // Local constants
    // ****************************************
    // Compared at the transmit counter's width
    localparam [TEC_W-1:0] BUS_OFF_LIM = `CRIE_BUS_OFF_LIMIT;

    // ****************************************
    // Registers and combinational terms
    // ****************************************
    reg wake_irq_enable;
    reg status_change_irq_enable;
    reg [1:0] rx_state_sensitivity;
    reg [1:0] tx_state_sensitivity;
    reg overrun_irq_enable;
    reg rx_full_irq_enable;

    reg wake_flag;
    reg status_change_flag;
    reg [1:0] rx_state_bits;
    reg [1:0] tx_state_bits;
    reg overrun_flag;
    reg rx_full_flag;

    wire init_mode;
    wire write_open;
    wire ien_write;
    wire flag_write;
    wire tx_bus_off;
    wire [1:0] rx_actual;
    wire [1:0] tx_actual;
    wire rx_hit;
    wire tx_hit;
    wire [7:0] ien_value;
    wire [7:0] flag_value;
    wire ien_sel;
    wire flag_sel;
    wire wake_set;
    wire wake_clear;
    wire status_clear;
    wire overrun_clear;
    wire rx_full_clear;
    reg [7:0] next_rdata;
    reg next_wake_irq;
    reg next_error_irq;
    reg next_rx_irq;
    reg next_irq;

    // ****************************************
    // Mode, write and clear decode
    // ****************************************

    // Controller mode decode
    assign init_mode = init_request_i & init_acknowledge_i;
    // Address match, shared by the write and read paths
    assign ien_sel = (reg_addr_i == `CRIE_ADDR_IEN);
    assign flag_sel = (reg_addr_i == `CRIE_ADDR_FLAG);
    // enable write gate; a half-entered init mode also refuses enable writes, while flag clears pass in any mode
    assign write_open = ~init_request_i & ~init_acknowledge_i;
    assign ien_write = reg_wr_i && ien_sel && write_open;
    assign flag_write = reg_wr_i && flag_sel;

    // Write one to clear, one strobe per flag; zeros leave a flag alone
    assign wake_clear = flag_write & reg_wdata_i[`CRIE_BIT_WAKE];
    assign status_clear = flag_write & reg_wdata_i[`CRIE_BIT_CSC];
    assign overrun_clear = flag_write & reg_wdata_i[`CRIE_BIT_OVR];
    assign rx_full_clear = flag_write & reg_wdata_i[`CRIE_BIT_RXF];

    // wake activity counts only with the controller's wake-up enable
    assign wake_set = wake_event_i & wake_up_enable_i;

    // bus-off from transmit counter
    // Shared by both encoders: bus-off also drives the receiver state
    assign tx_bus_off = (tx_err_count_i > BUS_OFF_LIM);

    assign ien_value = {wake_irq_enable, status_change_irq_enable, rx_state_sensitivity,
                        tx_state_sensitivity, overrun_irq_enable, rx_full_irq_enable};
    assign flag_value = {wake_flag, status_change_flag, rx_state_bits,
                         tx_state_bits, overrun_flag, rx_full_flag};

    // ****************************************
    // Error state encoders
    // ****************************************

    // Both encoders see one bus-off term, so they never disagree on it
    // receiver band, bus-off forced by transmitter
    crie_state_enc #(
        .CNT_W(REC_W)
    ) u_rx_enc (
        .err_count_i(rx_err_count_i),
        .bus_off_i(tx_bus_off),
        .shown_state_i(rx_state_bits),
        .sensitivity_i(rx_state_sensitivity),
        .actual_state_o(rx_actual),
        .change_hit_o(rx_hit)
    );

    // Transmitter uses the same bands on its own counter
    crie_state_enc #(
        .CNT_W(TEC_W)
    ) u_tx_enc (
        .err_count_i(tx_err_count_i),
        .bus_off_i(tx_bus_off),
        .shown_state_i(tx_state_bits),
        .sensitivity_i(tx_state_sensitivity),
        .actual_state_o(tx_actual),
        .change_hit_o(tx_hit)
    );

    // ****************************************
    // Interrupt enable register
    // ****************************************

    // Enable bits: reset in init mode, written only outside it
    // Init mode is sampled on the clock, so it takes hold one edge late
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wake_irq_enable <= 1'b0;
            status_change_irq_enable <= 1'b0;
            overrun_irq_enable <= 1'b0;
            rx_full_irq_enable <= 1'b0;
        end else if (init_mode) begin
            wake_irq_enable <= 1'b0;
            status_change_irq_enable <= 1'b0;
            overrun_irq_enable <= 1'b0;
            rx_full_irq_enable <= 1'b0;
        end else if (ien_write) begin
            wake_irq_enable <= reg_wdata_i[`CRIE_BIT_WAKE];
            status_change_irq_enable <= reg_wdata_i[`CRIE_BIT_CSC];
            overrun_irq_enable <= reg_wdata_i[`CRIE_BIT_OVR];
            rx_full_irq_enable <= reg_wdata_i[`CRIE_BIT_RXF];
        end
    end

    // Sensitivity fields survive init mode so a re-init keeps the filter setup
    // Written only outside init mode, like the enable bits
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_state_sensitivity <= `CRIE_STATE_RESET;
            tx_state_sensitivity <= `CRIE_STATE_RESET;
        end else if (ien_write) begin
            rx_state_sensitivity <= reg_wdata_i[`CRIE_RX_HI:`CRIE_RX_LO];
            tx_state_sensitivity <= reg_wdata_i[`CRIE_TX_HI:`CRIE_TX_LO];
        end
    end

    // ****************************************
    // Event flags, write one to clear
    // ****************************************

    // Simple sticky flags; a set in the clearing cycle wins
    // Init mode leaves these flags alone; only software clears them
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wake_flag <= 1'b0;
            overrun_flag <= 1'b0;
            rx_full_flag <= 1'b0;
        end else begin
            // Wake flag from the gated wake event
            if (wake_set) begin
                wake_flag <= 1'b1;
            end else if (wake_clear) begin
                wake_flag <= 1'b0;
            end
            if (overrun_event_i) begin
                overrun_flag <= 1'b1;
            end else if (overrun_clear) begin
                overrun_flag <= 1'b0;
            end
            if (rx_full_event_i) begin
                rx_full_flag <= 1'b1;
            end else if (rx_full_clear) begin
                rx_full_flag <= 1'b0;
            end
        end
    end

    // Status change flag and shown state bits
    // A change hidden by the freeze is caught once the flag clears,
    // since the filter compares against the shown state
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            status_change_flag <= 1'b0;
            rx_state_bits <= `CRIE_ST_OK;
            tx_state_bits <= `CRIE_ST_OK;
        end else if (status_change_flag) begin
            if (status_clear) begin
                status_change_flag <= 1'b0;
            end
        end else begin
            rx_state_bits <= rx_actual;
            tx_state_bits <= tx_actual;
            if (rx_hit || tx_hit) begin
                status_change_flag <= 1'b1;
            end
        end
    end

    // ****************************************
    // Interrupt requests
    // ****************************************

    // Level terms; the flop below adds one cycle of lag
    always @* begin
        next_wake_irq = wake_flag & wake_irq_enable;
        next_error_irq = (status_change_flag & status_change_irq_enable) |
                         (overrun_flag & overrun_irq_enable);
        next_rx_irq = rx_full_flag & rx_full_irq_enable;
        next_irq = next_wake_irq | next_error_irq | next_rx_irq;
    end

    // Registered so every output comes from a flop; one cycle behind the flags
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wake_irq_o <= 1'b0;
            error_irq_o <= 1'b0;
            rx_irq_o <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            wake_irq_o <= next_wake_irq;
            error_irq_o <= next_error_irq;
            rx_irq_o <= next_rx_irq;
            irq_o <= next_irq;
        end
    end

    // ****************************************
    // Read port
    // ****************************************

    // Read mux; unmapped addresses read zero
    always @* begin
        if (ien_sel) begin
            next_rdata = ien_value;
        end else if (flag_sel) begin
            next_rdata = flag_value;
        end else begin
            next_rdata = 8'h00;
        end
    end

    // Data is zero outside its slot, so a late sample cannot see stale data
    // reads allowed at any time; data valid only in the cycle after the strobe
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            reg_rdata_o <= next_rdata;
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end

endmodule

// *** tb/crie_checker.sv ***
`timescale 1ns/1ps
// ****************************************
// Port checker for the receive interrupt enable block
// ****************************************
module crie_checker #(
    parameter REC_W = 8,
    parameter TEC_W = 9
) (
    input wire clk_sys_i,
    input wire rst_n_i,
    input wire [7:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [7:0] reg_rdata_o,
    input wire init_request_i,
    input wire init_acknowledge_i,
    input wire wake_up_enable_i,
    input wire wake_event_i,
    input wire overrun_event_i,
    input wire rx_full_event_i,
    input wire wake_irq_o,
    input wire error_irq_o,
    input wire rx_irq_o,
    input wire irq_o
);
    reg [7:0] en_sh;
    wire init_mode = init_request_i & init_acknowledge_i;
    // Shadow enable register; bits 5:2 survive init mode
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            en_sh <= 8'h00;
        end else if (init_mode) begin
            en_sh <= en_sh & 8'h3C;
        end else if (reg_wr_i && reg_addr_i == 8'h05 && !init_request_i && !init_acknowledge_i) begin
            en_sh <= reg_wdata_i;
        end
    end
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    rd_enable_a: // enable readback
        assert property (reg_rd_i && reg_addr_i == 8'h05 |=> reg_rdata_o == $past(en_sh)) else $error("enable readback");
    rd_idle_a: // data one cycle
        assert property (!reg_rd_i |=> reg_rdata_o == 8'h00) else $error("read data outside slot");
    init_quiet_a: // init clears requests
        assert property (init_mode |-> ##2 !irq_o) else $error("request during init");
    wake_req_a: // wake request
        assert property (wake_event_i && wake_up_enable_i ##1 en_sh[7] |-> ##1 wake_irq_o) else $error("wake missed");
    wake_off_a: // wake masked
        assert property (!en_sh[7] |=> !wake_irq_o) else $error("masked wake");
    err_off_a: // error masked
        assert property (!en_sh[6] && !en_sh[1] |=> !error_irq_o) else $error("masked error");
    ovr_req_a: // overrun request
        assert property (overrun_event_i ##1 en_sh[1] |-> ##1 error_irq_o) else $error("overrun missed");
    rxf_req_a: // full request
        assert property (rx_full_event_i ##1 en_sh[0] |-> ##1 rx_irq_o) else $error("full missed");
    rxf_off_a: // full masked
        assert property (!en_sh[0] |=> !rx_irq_o) else $error("masked full");
endmodule

bind crie_top crie_checker #(.REC_W(REC_W), .TEC_W(TEC_W)) u_chk (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .init_request_i(init_request_i), .init_acknowledge_i(init_acknowledge_i),
    .wake_up_enable_i(wake_up_enable_i), .wake_event_i(wake_event_i), .overrun_event_i(overrun_event_i),
    .rx_full_event_i(rx_full_event_i), .wake_irq_o(wake_irq_o), .error_irq_o(error_irq_o),
    .rx_irq_o(rx_irq_o), .irq_o(irq_o));

// *** tb/crie_can_peer.sv ***
`timescale 1ns/1ps
// ****************************************
// Far side: protocol events and error counters
// ****************************************
module crie_can_peer (
    input wire clk_sys_i,
    output reg wake_o,
    output reg ovr_o,
    output reg rxf_o,
    output reg [7:0] rec_o,
    output reg [8:0] tec_o
);
    initial begin
        {wake_o, ovr_o, rxf_o, rec_o, tec_o} = 20'h00000;
    end
    // One-cycle pulse, so a single event is seen once
    task fire(input integer which);
        begin
            @(posedge clk_sys_i);
            case (which)
                7: wake_o <= 1'b1;
                1: ovr_o <= 1'b1;
                default: rxf_o <= 1'b1;
            endcase
            @(posedge clk_sys_i);
            {wake_o, ovr_o, rxf_o} <= 3'h0;
        end
    endtask
    // Counters move as levels, like the protocol engine
    task set_counts(input [7:0] r, input [8:0] t);
        begin
            @(posedge clk_sys_i);
            rec_o <= r;
            tec_o <= t;
        end
    endtask
endmodule

// *** tb/can_rx_irq_enable_tb.sv ***
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks = total_checks + 1; if ((g) !== (e)) begin bad_count = bad_count + 1; $display("[FAIL] %s expected %h seen %h", n, e, g); end end
// ****************************************
// Testbench
// ****************************************
module can_rx_irq_enable_tb;
    reg clk_sys_i = 1'b0;
    reg rst_n_i = 1'b0;
    reg [7:0] reg_addr = 8'h00;
    reg [7:0] reg_wdata = 8'h00;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    reg init_req = 1'b0;
    reg init_ack = 1'b0;
    reg wake_en = 1'b0;
    reg [7:0] v;
    reg got;
    wire [7:0] reg_rdata;
    wire wake_ev, ovr_ev, rxf_ev, wake_irq, err_irq, rx_irq, irq;
    wire [7:0] rec;
    wire [8:0] tec;
    integer total_checks = 0;
    integer bad_count = 0;
    integer k, on, b;
    always #4 clk_sys_i = ~clk_sys_i;
    crie_can_peer peer (.clk_sys_i(clk_sys_i), .wake_o(wake_ev), .ovr_o(ovr_ev), .rxf_o(rxf_ev), .rec_o(rec),
        .tec_o(tec));
    crie_top dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
        .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .init_request_i(init_req),
        .init_acknowledge_i(init_ack), .wake_up_enable_i(wake_en), .wake_event_i(wake_ev),
        .overrun_event_i(ovr_ev), .rx_full_event_i(rxf_ev), .rx_err_count_i(rec), .tx_err_count_i(tec),
        .wake_irq_o(wake_irq), .error_irq_o(err_irq), .rx_irq_o(rx_irq), .irq_o(irq));
    task cyc(input integer n);
        begin
            repeat (n) @(posedge clk_sys_i);
            #1;
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(posedge clk_sys_i);
            reg_wr <= 1'b1;
            reg_addr <= a;
            reg_wdata <= d;
            @(posedge clk_sys_i);
            reg_wr <= 1'b0;
        end
    endtask
    // Read data stand only in the cycle after the strobe
    task rd(input [7:0] a);
        begin
            @(posedge clk_sys_i);
            reg_rd <= 1'b1;
            reg_addr <= a;
            @(posedge clk_sys_i);
            reg_rd <= 1'b0;
            #1;
            v = reg_rdata;
        end
    endtask
    task init_bits(input rq, input ak);
        begin
            @(posedge clk_sys_i);
            init_req <= rq;
            init_ack <= ak;
        end
    endtask
    task test_init;
        begin
            wr(8'h05, 8'hFF);
            rd(8'h05);
            `CHK("enable write", 8'hFF, v)
            init_bits(1'b1, 1'b1);
            cyc(2);
            rd(8'h05);
            `CHK("init hold", 8'h3C, v)
            wr(8'h05, 8'h00);
            rd(8'h05);
            `CHK("init refuse", 8'h3C, v)
            init_bits(1'b1, 1'b0);
            wr(8'h05, 8'h00);
            rd(8'h05);
            `CHK("request refuse", 8'h3C, v)
            init_bits(1'b0, 1'b0);
            wr(8'h05, 8'h00);
            rd(8'h05);
            `CHK("enable clear", 8'h00, v)
            rd(8'h09);
            `CHK("unmapped read", 8'h00, v)
            $display("test init done");
        end
    endtask
    // Each event with its enable off, then on; wake also needs the wake-up enable
    task test_gates;
        begin
            @(posedge clk_sys_i);
            wake_en <= 1'b1;
            for (k = 0; k < 3; k = k + 1) begin
                b = (k == 0) ? 7 : (k == 1) ? 1 : 0;
                for (on = 0; on < 2; on = on + 1) begin
                    wr(8'h05, on[0] ? (8'h01 << b) : 8'h00);
                    peer.fire(b);
                    cyc(3);
                    got = (k == 0) ? wake_irq : (k == 1) ? err_irq : rx_irq;
                    `CHK("event request", on[0], got)
                    `CHK("any request", on[0], irq)
                    rd(8'h04);
                    `CHK("event flag", 8'h01 << b, v)
                    wr(8'h04, 8'h01 << b);
                    cyc(2);
                    `CHK("request drop", 1'b0, irq)
                end
            end
            @(posedge clk_sys_i);
            wake_en <= 1'b0;
            peer.fire(7);
            rd(8'h04);
            `CHK("wake ignored", 8'h00, v)
            $display("test gates done");
        end
    endtask
    task step(input [7:0] en, input [7:0] r, input [8:0] t, input f, input [3:0] st);
        begin
            wr(8'h05, en);
            peer.set_counts(r, t);
            cyc(4);
            `CHK("error request", f & en[6], err_irq)
            rd(8'h04);
            `CHK("status flag", f, v[6])
            `CHK("state bits", st, v[5:2])
            wr(8'h04, 8'h40);
            cyc(3);
        end
    endtask
    task test_status;
        begin
            step(8'h70, 8'd97, 9'd0, 1'b1, 4'h4);
            step(8'h60, 8'd96, 9'd0, 1'b0, 4'h0);
            step(8'h60, 8'd128, 9'd0, 1'b1, 4'h8);
            step(8'h50, 8'd100, 9'd0, 1'b0, 4'h4);
            step(8'h50, 8'd100, 9'd300, 1'b1, 4'hF);
            step(8'h44, 8'd0, 9'd0, 1'b1, 4'h0);
            step(8'h48, 8'd0, 9'd128, 1'b1, 4'h2);
            step(8'h4C, 8'd0, 9'd127, 1'b1, 4'h1);
            step(8'h48, 8'd0, 9'd0, 1'b0, 4'h0);
            step(8'h40, 8'd0, 9'd200, 1'b0, 4'h2);
            step(8'h30, 8'd130, 9'd200, 1'b1, 4'hA);
            $display("test status done");
        end
    endtask
    // A pending flag freezes the state bits; the missed change shows after the clear
    task test_freeze;
        begin
            wr(8'h05, 8'h70);
            peer.set_counts(8'd97, 9'd200);
            cyc(4);
            peer.set_counts(8'd0, 9'd200);
            cyc(4);
            rd(8'h04);
            `CHK("frozen state", 8'h58, v)
            wr(8'h04, 8'h40);
            cyc(4);
            rd(8'h04);
            `CHK("state after clear", 8'h48, v)
            `CHK("status request", 1'b1, err_irq)
            init_bits(1'b1, 1'b1);
            cyc(2);
            `CHK("init drops request", 1'b0, irq)
            rd(8'h05);
            `CHK("init keeps fields", 8'h30, v)
            init_bits(1'b0, 1'b0);
            $display("test freeze done");
        end
    endtask
    task close_out;
        begin
            $display("checks %0d mismatches %0d", total_checks, bad_count);
            if (bad_count == 0 && total_checks > 0) begin
                $display("ALL CHECKS OK");
            end else begin
                $display("CHECKS NOT OK");
            end
            $finish;
        end
    endtask
    initial begin
        repeat (100000) @(posedge clk_sys_i);
        bad_count = bad_count + 1;
        close_out;
    end
    initial begin
        repeat (20) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        rd(8'h05);
        `CHK("enable reset", 8'h00, v)
        rd(8'h04);
        `CHK("flag reset", 8'h00, v)
        $display("test reset done");
        test_init;
        test_gates;
        test_status;
        test_freeze;
        close_out;
    end
endmodule
